// ---- hdl/visr_irq_status.sv ----
// interrupt collection, software and edge requests, and bus interrupter level
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`include "visr_regs.svh"
module visr_irq_status
    import visr_pkg::*;
#(
    parameter int NUM_CPU = 4,
    parameter int NUM_SWI = 8
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic                    pready,
    output logic [31:0]             prdata,
    output logic                    pslverr,
    input  wire logic               system_reset,
    input  wire logic               local_reset,
    input  wire logic               serial_ctrl_request,
    input  wire logic               high_prio_signal_bit,
    input  wire logic               low_prio_signal_bit,
    input  wire logic [3:0]         loc_monitor_flag_n,
    input  wire logic [7:1]         vme_irq_n,
    input  wire visr_event_s        events,
    input  wire visr_iack_s         iack,
    output logic [7:1]              vme_irq_out_n,
    output logic [7:0]              iack_data,
    output logic                    iack_data_oe,
    output logic [NUM_CPU-1:0]      cpu_irq
);

    logic                    soft_rst;
    logic                    wr_en;
    logic                    rd_en;
    logic                    wr_swi_set;
    logic                    wr_swi_clr;
    logic                    wr_edge_clr;
    logic                    wr_level;
    logic                    wr_vector;
    logic                    wr_en_all;
    logic [NUM_SWI-1:0]      soft_irq_bit;
    logic [NUM_SWI-1:0]      next_soft_irq_bit;
    logic [2:0]              raw_state;
    logic [2:0]              raw_prev;
    logic [2:0]              raw_rise;
    logic [2:0]              edge_req;
    logic [2:0]              next_edge_req;
    logic [2:0]              bus_request_level;
    logic [2:0]              next_bus_request_level;
    logic [7:0]              interrupter_vector;
    logic [7:0]              next_interrupter_vector;
    logic [31:0]             cpu_irq_enable [NUM_CPU];
    logic [31:0]             next_cpu_irq_enable [NUM_CPU];
    logic                    next_cpu_irq [NUM_CPU];
    logic [31:0]             status_word;
    logic [31:0]             rd_word;
    logic [31:0]             next_prdata;
    logic                    iack_match;
    visr_phase_e             phase;
    visr_phase_e             next_phase;

    assign soft_rst = system_reset | local_reset;
    // zero-wait slave: every access completes in its first access cycle
    assign pready   = 1'b1;
    assign pslverr  = 1'b0;
    assign wr_en    = psel & penable & pwrite;
    // the read address is taken in the setup cycle
    assign rd_en    = psel & ~penable & ~pwrite;

    // one strobe per writable location except the per-processor enable words, decoded in the loop below; each lands in its access cycle
    assign wr_swi_set  = wr_en && (paddr == `VISR_OFF_SWI_SET);
    assign wr_swi_clr  = wr_en && (paddr == `VISR_OFF_SWI_CLR);
    assign wr_edge_clr = wr_en && (paddr == `VISR_OFF_EDGE_CLR);
    assign wr_level    = wr_en && (paddr == `VISR_OFF_REQ_LEVEL);
    assign wr_vector   = wr_en && (paddr == `VISR_OFF_VECTOR);
    assign wr_en_all   = wr_en && (paddr == `VISR_OFF_EN_ALL);

    // bus phase: the access cycle is the one after a setup cycle
    always_comb begin
        case (phase)
            VISR_IDLE: begin
                next_phase = (psel && !penable) ? VISR_ACCESS : VISR_IDLE;
            end
            VISR_ACCESS: begin
                next_phase = VISR_IDLE;
            end
            default: begin
                next_phase = VISR_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= VISR_IDLE;
        end else begin
            phase <= next_phase;
        end
    end

    assign raw_state = {events.abort_pressed, ~events.acfail_n, ~events.sysfail_n};
    assign raw_rise  = raw_state & ~raw_prev;

    always_comb begin
        status_word = 32'h0000_0000;
        // edge-latched requests
        status_word[`VISR_BIT_ABORT_EDGE_REQUEST]   = edge_req[2];
        status_word[`VISR_BIT_ACF]    = edge_req[1];
        status_word[`VISR_BIT_SF]     = edge_req[0];
        // live request levels from neighbouring sources
        status_word[`VISR_BIT_SERIAL] = serial_ctrl_request;
        status_word[`VISR_BIT_HP_SIG] = high_prio_signal_bit;
        status_word[`VISR_BIT_LP_SIG] = low_prio_signal_bit;
        // bus lines are active low and shown as 1 while asserted
        status_word[`VISR_BIT_IRQ5]   = ~vme_irq_n[5];
        status_word[`VISR_BIT_IRQ4]   = ~vme_irq_n[4];
        status_word[`VISR_BIT_IRQ3]   = ~vme_irq_n[3];
        status_word[`VISR_BIT_IRQ2]   = ~vme_irq_n[2];
        status_word[`VISR_BIT_IRQ1]   = ~vme_irq_n[1];
        status_word[`VISR_BIT_LMI]    = ~(&loc_monitor_flag_n);
        // software bits split over a low and a high nibble field
        status_word[`VISR_SWI_LO +: 4] = soft_irq_bit[3:0];
        status_word[`VISR_SWI_HI_POS +: 4] = soft_irq_bit[7:4];
    end

    // software bits: set wins when the same bit is set and cleared at once
    always_comb begin
        next_soft_irq_bit = soft_irq_bit;

        if (wr_swi_clr) begin
            next_soft_irq_bit = soft_irq_bit & ~pwdata[NUM_SWI-1:0];
        end

        if (wr_swi_set) begin
            next_soft_irq_bit = soft_irq_bit | pwdata[NUM_SWI-1:0];
        end

        if (soft_rst) begin
            next_soft_irq_bit = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_irq_bit <= '0;
        end else begin
            soft_irq_bit <= next_soft_irq_bit;
        end
    end

    // edge requests: a new edge in the clearing cycle still latches
    always_comb begin
        next_edge_req = edge_req;

        if (wr_edge_clr) begin
            next_edge_req = edge_req & ~pwdata[2:0];
        end

        // a source held active never re-arms: only a fresh rise sets again
        next_edge_req = next_edge_req | raw_rise;

        if (soft_rst) begin
            next_edge_req = 3'h0;
        end
    end

    // raw_prev resets to the inactive level, so idle sources give no false edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_prev <= 3'h0;
            edge_req <= 3'h0;
        end else begin
            raw_prev <= raw_state;
            edge_req <= next_edge_req;
        end
    end

    assign iack_match = iack.cycle_done && (bus_request_level != 3'h0)
                        && (iack.level == bus_request_level);

    always_comb begin
        next_bus_request_level = bus_request_level;

        if (wr_level) begin
            next_bus_request_level = pwdata[2:0];
        end

        // an acknowledge of the held level beats a write in the same cycle
        if (iack_match) begin
            next_bus_request_level = 3'h0;
        end

        if (soft_rst) begin
            next_bus_request_level = `VISR_RESET_LEVEL;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_request_level <= `VISR_RESET_LEVEL;
        end else begin
            bus_request_level <= next_bus_request_level;
        end
    end

    always_comb begin
        next_interrupter_vector = interrupter_vector;

        // frozen while a request is pending, so the handler reads a stable vector
        if (wr_vector && bus_request_level == 3'h0) begin
            next_interrupter_vector = pwdata[7:0];
        end

        if (soft_rst) begin
            next_interrupter_vector = `VISR_RESET_VECTOR;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupter_vector <= `VISR_RESET_VECTOR;
        end else begin
            interrupter_vector <= next_interrupter_vector;
        end
    end

    // the write-all location updates every processor word at once
    genvar gc;
    generate
        for (gc = 0; gc < NUM_CPU; gc++) begin : g_cpu
            always_comb begin
                next_cpu_irq_enable[gc] = cpu_irq_enable[gc];

                if (wr_en_all || (wr_en && paddr == 12'(`VISR_OFF_EN0 + 4 * gc))) begin
                    next_cpu_irq_enable[gc] = pwdata;
                end

                if (soft_rst) begin
                    next_cpu_irq_enable[gc] = `VISR_RESET_ENABLE;
                end

                // registered one cycle behind the status so the output comes from a flop
                next_cpu_irq[gc] = |(status_word & cpu_irq_enable[gc]);
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cpu_irq_enable[gc] <= `VISR_RESET_ENABLE;
                    cpu_irq[gc]        <= 1'b0;
                end else begin
                    cpu_irq_enable[gc] <= next_cpu_irq_enable[gc];
                    cpu_irq[gc]        <= next_cpu_irq[gc];
                end
            end
        end
    endgenerate

    // live value of the addressed register; unmapped locations read 0
    always_comb begin
        rd_word = 32'h0000_0000;
        case (paddr)
            `VISR_OFF_STATUS: begin
                rd_word = status_word;
            end
            `VISR_OFF_RAW_STATE: begin
                rd_word = {29'h0, raw_state};
            end
            `VISR_OFF_REQ_LEVEL: begin
                rd_word = {29'h0, bus_request_level};
            end
            `VISR_OFF_VECTOR: begin
                rd_word = {24'h0, interrupter_vector};
            end
            default: begin
                rd_word = 32'h0000_0000;
                for (int i = 0; i < NUM_CPU; i++) begin
                    if (paddr == 12'(`VISR_OFF_EN0 + 4 * i)) begin
                        rd_word = cpu_irq_enable[i];
                    end
                end
            end
        endcase
    end

    // read data registered in the setup cycle, held through the access cycle
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (rd_en) begin
            next_prdata = rd_word;
        end else if (phase == VISR_ACCESS) begin
            next_prdata = prdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= next_prdata;
        end
    end

    // request line and vector outputs follow registered state directly
    always_comb begin
        for (int l = 1; l <= 7; l++) begin
            vme_irq_out_n[l] = ~(bus_request_level == 3'(l));
        end
    end

    assign iack_data    = interrupter_vector;
    // offered whenever the address level matches; the bus side qualifies it
    assign iack_data_oe = (bus_request_level != 3'h0)
                          && (iack.level == bus_request_level);

endmodule

// ---- hdl/visr_regs.svh ----
// register offsets, field positions and reset values of the interrupt status block
`ifndef VISR_REGS_SVH
`define VISR_REGS_SVH
`define VISR_OFF_STATUS     12'h000
`define VISR_OFF_SWI_SET    12'h004
`define VISR_OFF_SWI_CLR    12'h008
`define VISR_OFF_RAW_STATE  12'h00c
`define VISR_OFF_EDGE_CLR   12'h010
`define VISR_OFF_REQ_LEVEL  12'h014
`define VISR_OFF_VECTOR     12'h018
`define VISR_OFF_EN0        12'h020
`define VISR_OFF_EN_ALL     12'h030
`define VISR_BIT_ABORT_EDGE_REQUEST       31
`define VISR_BIT_ACF        30
`define VISR_BIT_SF         20
`define VISR_BIT_SERIAL     17
`define VISR_BIT_HP_SIG     16
`define VISR_BIT_IRQ5       14
`define VISR_BIT_IRQ4       12
`define VISR_BIT_IRQ3       10
`define VISR_BIT_LMI        8
`define VISR_BIT_LP_SIG     7
`define VISR_BIT_IRQ2       6
`define VISR_BIT_IRQ1       4
`define VISR_SWI_LO         0
`define VISR_SWI_HI_POS     24
`define VISR_RESET_LEVEL    3'h0
`define VISR_RESET_VECTOR   8'h00
`define VISR_RESET_ENABLE   32'h0000_0000
`endif

// ---- hdl/visr_pkg.sv ----
// types shared by the interrupt status block
package visr_pkg;
    typedef struct packed {
        logic abort_pressed;
        logic acfail_n;
        logic sysfail_n;
    } visr_event_s;
    typedef struct packed {
        logic       cycle_done;
        logic [2:0] level;
    } visr_iack_s;
    typedef enum logic [1:0] {
        VISR_IDLE   = 2'b00,
        VISR_ACCESS = 2'b01
    } visr_phase_e;
endpackage

// ---- bench/visr_irq_status_checker.sv ----
// port assertions for the interrupt status block
`timescale 1ns/1ns
module visr_irq_status_checker
    import visr_pkg::*;
#(
    parameter int NUM_CPU = 4
) (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               system_reset,
    input wire logic               local_reset,
    input wire visr_iack_s         iack,
    input wire logic [7:1]         vme_irq_out_n,
    input wire logic [7:0]         iack_data,
    input wire logic               iack_data_oe,
    input wire logic [NUM_CPU-1:0] cpu_irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire req   = !(&vme_irq_out_n);
    // level 0 would index outside the line range, the guard keeps it out
    wire match = iack.level != 3'h0 && !vme_irq_out_n[iack.level];
    one_request_a: assert property ($onehot0(~vme_irq_out_n))
        else $error("several request lines low");
    oe_needs_match_a: assert property (iack_data_oe |-> match)
        else $error("vector driven without matching level");
    oe_on_match_a: assert property (match |-> iack_data_oe)
        else $error("matching acknowledge not answered");
    level_clear_a: assert property (iack.cycle_done && match |=> !req)
        else $error("request kept after acknowledge");
    reset_level_a: assert property (local_reset || system_reset |=> !req)
        else $error("request kept after reset");
    reset_cpu_a: assert property (system_reset |-> ##2 cpu_irq == '0)
        else $error("processor interrupt after reset");
    vector_hold_a: assert property ($past(req) && !$past(system_reset || local_reset)
        |-> $stable(iack_data)) else $error("vector changed while requesting");
    drop_cause_a: assert property ($rose(&vme_irq_out_n)
        |-> $past(iack.cycle_done || system_reset || local_reset || psel))
        else $error("request dropped without cause");
    cover property (iack.cycle_done && match);
    cover property (cpu_irq != '0);
    cover property (!vme_irq_out_n[7]);
endmodule
bind visr_irq_status visr_irq_status_checker #(.NUM_CPU(NUM_CPU)) i_visr_irq_status_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .system_reset(system_reset),
    .local_reset(local_reset), .iack(iack), .vme_irq_out_n(vme_irq_out_n),
    .iack_data(iack_data), .iack_data_oe(iack_data_oe), .cpu_irq(cpu_irq));

// ---- bench/visr_handler_model.sv ----
// behavioural bus interrupt handler that acknowledges the block's requests
`timescale 1ns/1ns
module visr_handler_model
    import visr_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [7:1] vme_irq_out_n,
    input  wire logic [7:0] iack_data,
    input  wire logic       iack_data_oe,
    input  wire logic [3:0] delay,
    output visr_iack_s      iack,
    output logic [7:0]      got_vector,
    output int              acks
);
    logic [3:0] cnt;
    logic [2:0] lvl;
    always_comb begin
        lvl = 3'h0;
        for (int i = 1; i < 8; i++) begin
            if (!vme_irq_out_n[i]) begin
                lvl = 3'(i);
            end
        end
    end
    // idle address lines keep moving so a stale level never passes for a real one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt        <= 4'h0;
            iack       <= '0;
            got_vector <= 8'h00;
            acks       <= 0;
        end else if (iack.cycle_done) begin
            iack.cycle_done <= 1'b0;
            got_vector      <= iack_data_oe ? iack_data : 8'h00;
            acks            <= acks + 1;
            cnt             <= 4'h0;
        end else if (lvl == 3'h0 || cnt != delay) begin
            cnt        <= (lvl == 3'h0) ? 4'h0 : cnt + 4'h1;
            iack.level <= iack.level + 3'h1;
        end else begin
            iack <= '{cycle_done: 1'b1, level: lvl};
        end
    end
endmodule

// ---- bench/vme_interrupt_status_request_tb.sv ----
// self-checking bench for the interrupt status block
`timescale 1ns/1ns
`include "visr_regs.svh"
module vme_interrupt_status_request_tb;
    import visr_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, oe;
    logic        system_reset, local_reset, serial, hp_sig, lp_sig;
    logic [3:0]  lm_n, cpu_irq, delay;
    logic [7:1]  vme_irq_n, irq_out_n;
    logic [7:0]  iack_data, got_vector;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    visr_event_s events;
    visr_iack_s  iack;
    int          acks, bad_count, samples_checked, n, a0;
    // {serial, high, low, monitor_n, irq_n[5:1]} beside the expected status word
    logic [43:0] rows [8] = '{
        {12'h9ff, 32'h0002_0000}, {12'h5ff, 32'h0001_0000}, {12'h3ff, 32'h0000_0080},
        {12'h1df, 32'h0000_0100}, {12'h0ff, 32'h0000_0100}, {12'h1fe, 32'h0000_0010},
        {12'h1e0, 32'h0000_5450}, {12'h1ff, 32'h0000_0000}};
    visr_irq_status i_visr_irq_status (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .system_reset(system_reset), .local_reset(local_reset), .serial_ctrl_request(serial),
        .high_prio_signal_bit(hp_sig), .low_prio_signal_bit(lp_sig),
        .loc_monitor_flag_n(lm_n), .vme_irq_n(vme_irq_n), .events(events), .iack(iack),
        .vme_irq_out_n(irq_out_n), .iack_data(iack_data), .iack_data_oe(oe), .cpu_irq(cpu_irq));
    visr_handler_model i_visr_handler_model (.pclk(pclk), .presetn(presetn),
        .vme_irq_out_n(irq_out_n), .iack_data(iack_data), .iack_data_oe(oe),
        .delay(delay), .iack(iack), .got_vector(got_vector), .acks(acks));
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            bad_count++;
            summarize();
        end
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        // an idle edge keeps the next setup from landing in this time step
        @(posedge pclk);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, system_reset, local_reset} = 6'h00;
        {serial, hp_sig, lp_sig, lm_n, vme_irq_n[5:1]} = 12'h1ff;
        vme_irq_n[7:6] = 2'h3;
        events = 3'b011;
        delay = 4'h2;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b1, `VISR_OFF_EN_ALL, 32'hffff_ffff);
        for (int i = 0; i < 8; i++) begin
            {serial, hp_sig, lp_sig, lm_n, vme_irq_n[5:1]} <= rows[i][43:32];
            repeat (3) @(posedge pclk);
            chk({28'h0, cpu_irq}, {28'h0, {4{rows[i][31:0] != 32'h0}}});
            rdchk(`VISR_OFF_STATUS, rows[i][31:0]);
        end
        $display("status rows done");
        rdchk(12'h0fc, 32'h0);
        apb(1'b1, `VISR_OFF_SWI_SET, 32'h0000_00a5);
        rdchk(`VISR_OFF_STATUS, 32'h0a00_0005);
        apb(1'b1, `VISR_OFF_SWI_CLR, 32'h0000_0081);
        rdchk(`VISR_OFF_STATUS, 32'h0200_0004);
        events <= 3'b100;
        repeat (3) @(posedge pclk);
        rdchk(`VISR_OFF_RAW_STATE, 32'h7);
        rdchk(`VISR_OFF_STATUS, 32'hc210_0004);
        apb(1'b1, `VISR_OFF_EDGE_CLR, 32'h5);
        rdchk(`VISR_OFF_STATUS, 32'h4200_0004);
        events <= 3'b011;
        repeat (3) @(posedge pclk);
        rdchk(`VISR_OFF_RAW_STATE, 32'h0);
        apb(1'b1, `VISR_OFF_EDGE_CLR, 32'h2);
        events <= 3'b010;
        repeat (3) @(posedge pclk);
        rdchk(`VISR_OFF_STATUS, 32'h0210_0004);
        $display("soft and edge requests done");
        delay <= 4'hf;
        for (int j = 0; j < 2; j++) begin
            apb(1'b1, `VISR_OFF_SWI_SET, 32'h0000_0010);
            apb(1'b1, `VISR_OFF_REQ_LEVEL, 32'h5);
            {system_reset, local_reset} <= 2'(j + 1);
            @(posedge pclk);
            {system_reset, local_reset} <= 2'b00;
            rdchk(`VISR_OFF_STATUS, 32'h0);
            rdchk(`VISR_OFF_REQ_LEVEL, 32'h0);
            rdchk(`VISR_OFF_EN0, 32'h0);
            apb(1'b1, `VISR_OFF_EN_ALL, 32'hffff_ffff);
        end
        $display("resets done");
        apb(1'b1, `VISR_OFF_VECTOR, 32'h5a);
        for (int l = 1; l < 8; l++) begin
            // the handler waits long enough for the vector write below to meet a pending level
            delay <= 4'(2 * l);
            rdchk(`VISR_OFF_REQ_LEVEL, 32'h0);
            apb(1'b1, `VISR_OFF_REQ_LEVEL, 32'(l));
            chk({25'h0, irq_out_n}, {25'h0, ~(7'h1 << (l - 1))});
            apb(1'b1, `VISR_OFF_VECTOR, 32'hc3);
            a0 = acks;
            for (n = 0; acks == a0 && n < 100; n++) @(posedge pclk);
            if (acks == a0) begin
                bad_count++;
                summarize();
            end
            chk({24'h0, got_vector}, 32'h5a);
            rdchk(`VISR_OFF_REQ_LEVEL, 32'h0);
        end
        delay <= 4'hf;
        apb(1'b1, `VISR_OFF_REQ_LEVEL, 32'h2);
        apb(1'b1, `VISR_OFF_REQ_LEVEL, 32'h0);
        chk({25'h0, irq_out_n}, 32'h7f);
        apb(1'b1, `VISR_OFF_VECTOR, 32'h3c);
        rdchk(`VISR_OFF_VECTOR, 32'h3c);
        $display("bus requests done");
        summarize();
    end
endmodule
